// ===== rtl/standby_wake_control.sv
`timescale 1ns/1ps
`include "standby_wake_regs.svh"

// Overview of operation
// - test event sets its flag, no vectoring
// - each test event raises standby release request
// - two sources: watch overflow, key port falls
// - watch overflow sets the watch flag
// - any key pin falling sets key flag
// - key flag holds until software clears it
// - reset loads request flags with zero
// - mask gates watch release; reset masks all
// - key control enables key release; reset 02
// - halt stops cpu clock, oscillator keeps running
// - stop turns the main oscillator off
// - standby keeps every register and latch except the oscillator synchroniser, cleared in stop
// - select code picks 2^12..2^17 clock wait
// - wait counts main clock, doubled when main clock is halved
// - settle select register resets to code four
// - reset release waits 2^17 oscillator periods
// - counting starts only once oscillation runs
// - unmasked interrupt ends halt
// - unmasked test ends halt; masked stays
// - unmasked test ends stop after the wait
// - pending interrupt at stop skips stop, runs the settle wait

module standby_wake_control
    import standby_wake_pkg::*;
#(
    parameter int SETTLE_CYC_0 = `SETTLE_CYC_0,
    // longer waits follow the shortest and keep their fixed ratios,
    // so a single override scales the whole table
    parameter int SETTLE_CYC_1 =
        SETTLE_CYC_0 * (`SETTLE_CYC_1 / `SETTLE_CYC_0),
    parameter int SETTLE_CYC_2 =
        SETTLE_CYC_0 * (`SETTLE_CYC_2 / `SETTLE_CYC_0),
    parameter int SETTLE_CYC_3 =
        SETTLE_CYC_0 * (`SETTLE_CYC_3 / `SETTLE_CYC_0),
    parameter int SETTLE_CYC_4 =
        SETTLE_CYC_0 * (`SETTLE_CYC_4 / `SETTLE_CYC_0),
    parameter int RESET_SETTLE_CYC =
        SETTLE_CYC_0 * (`RESET_SETTLE_CYC / `SETTLE_CYC_0)
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic irq_pending,
    input wire logic watch_overflow_event,
    input wire logic [7:0] key_port_pins,
    input wire logic oscillation_divide_select,
    input wire logic osc_running,
    output logic cpu_clock_enable,
    output logic osc_enable,
    output logic halt_active,
    output logic stop_active,
    output logic release_req,
    output logic resume
);

localparam int CW = `SETTLE_CNT_W;
localparam int MAX_CYC = 1 << (CW - 2);

if (SETTLE_CYC_0 < 1 || SETTLE_CYC_0 > MAX_CYC ||
    SETTLE_CYC_1 < 1 || SETTLE_CYC_1 > MAX_CYC ||
    SETTLE_CYC_2 < 1 || SETTLE_CYC_2 > MAX_CYC ||
    SETTLE_CYC_3 < 1 || SETTLE_CYC_3 > MAX_CYC ||
    SETTLE_CYC_4 < 1 || SETTLE_CYC_4 > MAX_CYC ||
    RESET_SETTLE_CYC < 1 || RESET_SETTLE_CYC > MAX_CYC) begin : g_chk
    $error("standby_wake_control: settle count out of range");
end

standby_regs_t cur_ff;
standby_regs_t nxt_cur;
logic key_fall;
logic wake_test;
logic wake_any;
logic settle_run;
logic settle_done;
logic [CW-1:0] base_cyc;
logic [CW-1:0] settle_target;

////////////////////////////////////////////////////////////////////////////
// settle wait length

always_comb begin
    unique case (cur_ff.settle_sel)
        `SETTLE_CODE_0: base_cyc = CW'(SETTLE_CYC_0);
        `SETTLE_CODE_1: base_cyc = CW'(SETTLE_CYC_1);
        `SETTLE_CODE_2: base_cyc = CW'(SETTLE_CYC_2);
        `SETTLE_CODE_3: base_cyc = CW'(SETTLE_CYC_3);
        `SETTLE_CODE_4: base_cyc = CW'(SETTLE_CYC_4);
        // prohibited codes fall back to the longest wait, the safe side
        default: base_cyc = CW'(SETTLE_CYC_4);
    endcase
end

// the block runs on the oscillator; an undivided main clock doubles
// nothing, a halved one needs twice the oscillator periods
always_comb begin
    if (cur_ff.reset_wait) begin
        settle_target = CW'(RESET_SETTLE_CYC);
    end else if (oscillation_divide_select) begin
        settle_target = base_cyc;
    end else begin
        settle_target = {base_cyc[CW-2:0], 1'b0};
    end
end

assign settle_run = (cur_ff.state == ST_SETTLE);

settle_counter #(
    .CNT_W(CW)
) u_settle (
    .clock(clock),
    .rst(rst),
    .run(settle_run),
    .target(settle_target),
    .done(settle_done)
);

////////////////////////////////////////////////////////////////////////////
// test inputs and wake decision

// synchronised key pins, edge taken on the second stage only
assign key_fall = |(cur_ff.key_prev & ~cur_ff.key_sync2);

assign wake_test =
    (cur_ff.req_flags[`WATCH_FLAG_BIT] &
     ~cur_ff.mask_flags[`WATCH_MASK_BIT]) |
    (cur_ff.key_ctl[`KEY_FLAG_BIT] &
     ~cur_ff.key_ctl[`KEY_MASK_BIT]);
assign wake_any = irq_pending | wake_test;

always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.resume = 1'b0;
    nxt_cur.key_sync1 = key_port_pins;
    nxt_cur.key_sync2 = cur_ff.key_sync1;
    nxt_cur.key_prev = cur_ff.key_sync2;
    nxt_cur.osc_sync1 = osc_running;
    nxt_cur.osc_sync2 = cur_ff.osc_sync1;
    // a stopped oscillator must not leave a stale running indication
    // in the synchroniser, or the wait would start before oscillation
    if (cur_ff.state == ST_STOP) begin
        nxt_cur.osc_sync1 = 1'b0;
        nxt_cur.osc_sync2 = 1'b0;
    end
    // events only flag and request release; no vector is produced
    nxt_cur.release_req = watch_overflow_event | key_fall;

    // register writes; hardware set wins over a same-cycle clear
    if (cpu_wr) begin
        unique case (cpu_addr)
            `SETTLE_SEL_ADDR: begin
                nxt_cur.settle_sel = cpu_wdata[`SETTLE_SEL_W-1:0];
            end
            `REQ_FLAGS_ADDR: begin
                nxt_cur.req_flags = cpu_wdata;
            end
            `MASK_FLAGS_ADDR: begin
                nxt_cur.mask_flags = cpu_wdata;
            end
            `KEY_CTL_ADDR: begin
                nxt_cur.key_ctl = cpu_wdata[`KEY_CTL_W-1:0];
            end
            default: begin
            end
        endcase
    end
    if (watch_overflow_event) begin
        nxt_cur.req_flags[`WATCH_FLAG_BIT] = 1'b1;
    end
    if (key_fall) begin
        nxt_cur.key_ctl[`KEY_FLAG_BIT] = 1'b1;
    end

    // registered read; unmapped addresses read zero
    if (cpu_rd) begin
        unique case (cpu_addr)
            `SETTLE_SEL_ADDR: nxt_cur.rd_data = {5'h00, cur_ff.settle_sel};
            `REQ_FLAGS_ADDR: nxt_cur.rd_data = cur_ff.req_flags;
            `MASK_FLAGS_ADDR: nxt_cur.rd_data = cur_ff.mask_flags;
            `KEY_CTL_ADDR: nxt_cur.rd_data = {6'h00, cur_ff.key_ctl};
            default: nxt_cur.rd_data = 8'h00;
        endcase
    end

    // standby keeps register contents; the case below changes only state, resume and reset_wait
    unique case (cur_ff.state)
        ST_RUN: begin
            if (stop_exec) begin
                if (wake_any) begin
                    nxt_cur.state = ST_SETTLE;
                end else begin
                    nxt_cur.state = ST_STOP;
                end
            end else if (halt_exec) begin
                nxt_cur.state = ST_HALT;
            end
        end
        ST_HALT: begin
            if (wake_any) begin
                nxt_cur.state = ST_RUN;
                nxt_cur.resume = 1'b1;
            end
        end
        ST_STOP: begin
            if (wake_any) begin
                nxt_cur.state = ST_OSC_WAIT;
            end
        end
        ST_OSC_WAIT: begin
            if (cur_ff.osc_sync2) begin
                nxt_cur.state = ST_SETTLE;
            end
        end
        ST_SETTLE: begin
            if (settle_done) begin
                nxt_cur.state = ST_RUN;
                nxt_cur.resume = 1'b1;
                nxt_cur.reset_wait = 1'b0;
            end
        end
    endcase
end

always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
        // reset release waits for oscillation, then the reset wait
        cur_ff.state <= ST_OSC_WAIT;
        cur_ff.req_flags <= `REQ_FLAGS_RESET;
        cur_ff.mask_flags <= `MASK_FLAGS_RESET;
        cur_ff.key_ctl <= `KEY_CTL_RESET;
        cur_ff.settle_sel <= `SETTLE_SEL_RESET;
        // pins idle high, so no false edge right after reset
        cur_ff.key_sync1 <= 8'hFF;
        cur_ff.key_sync2 <= 8'hFF;
        cur_ff.key_prev <= 8'hFF;
        cur_ff.osc_sync1 <= 1'b0;
        cur_ff.osc_sync2 <= 1'b0;
        cur_ff.reset_wait <= 1'b1;
        cur_ff.release_req <= 1'b0;
        cur_ff.resume <= 1'b0;
        cur_ff.rd_data <= 8'h00;
    end else begin
        cur_ff <= nxt_cur;
    end
end

assign cpu_rdata = cur_ff.rd_data;
assign cpu_clock_enable = (cur_ff.state == ST_RUN);
assign osc_enable = (cur_ff.state != ST_STOP);
assign halt_active = (cur_ff.state == ST_HALT);
assign stop_active = (cur_ff.state == ST_STOP);
assign release_req = cur_ff.release_req;
assign resume = cur_ff.resume;

////////////////////////////////////////////////////////////////////////////
// checks

logic [CW-1:0] dwell_ff;

always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
        dwell_ff <= '0;
    end else if (cur_ff.state == ST_SETTLE) begin
        dwell_ff <= dwell_ff + 1'b1;
    end else begin
        dwell_ff <= '0;
    end
end

default clocking cb @(posedge clock);
endclocking
default disable iff (rst);

sequence s_halt_wake;
    (cur_ff.state == ST_HALT) ##0 irq_pending;
endsequence

sequence s_stop_test;
    (cur_ff.state == ST_STOP) ##0 (wake_test && !irq_pending);
endsequence

watch_flag_set_a: assert property (
    watch_overflow_event |=>
    cur_ff.req_flags[`WATCH_FLAG_BIT] && release_req)
    else $error("watch event did not set flag and request");

key_flag_hold_a: assert property (
    cur_ff.key_ctl[`KEY_FLAG_BIT] &&
    !(cpu_wr && cpu_addr == `KEY_CTL_ADDR) |=>
    cur_ff.key_ctl[`KEY_FLAG_BIT])
    else $error("key flag cleared without a write");

halt_clock_a: assert property (
    halt_active |-> !cpu_clock_enable && osc_enable)
    else $error("halt state with wrong clocks");

stop_osc_a: assert property (
    (cur_ff.state == ST_RUN) && stop_exec && !wake_any |=>
    !osc_enable && stop_active)
    else $error("stop did not turn oscillator off");

halt_masked_a: assert property (
    halt_active && !irq_pending && !wake_test |=> halt_active)
    else $error("halt left without an unmasked source");

halt_wake_a: assert property (
    s_halt_wake |=> cpu_clock_enable && resume)
    else $error("interrupt did not end halt");

stop_wake_a: assert property (
    s_stop_test |=> (cur_ff.state == ST_OSC_WAIT) && osc_enable &&
    !cpu_clock_enable)
    else $error("test input did not release stop");

osc_wait_a: assert property (
    (cur_ff.state == ST_OSC_WAIT) && !cur_ff.osc_sync2 |=>
    (cur_ff.state == ST_OSC_WAIT))
    else $error("settle began before oscillation");

stop_pending_a: assert property (
    (cur_ff.state == ST_RUN) && stop_exec && irq_pending |=>
    (cur_ff.state == ST_SETTLE) && osc_enable)
    else $error("pending interrupt at stop not handled");

settle_len_a: assert property (
    settle_done |-> (dwell_ff == settle_target - 1'b1) ##1 resume)
    else $error("settle wait length wrong");

key_flag_set_a: assert property (
    key_fall |=> cur_ff.key_ctl[`KEY_FLAG_BIT] && release_req)
    else $error("key edge did not set flag and request");

osc_stale_a: assert property (
    stop_active |=> !cur_ff.osc_sync2)
    else $error("oscillator seen running during stop");

endmodule // standby_wake_control

// ===== rtl/standby_wake_regs.svh
`ifndef STANDBY_WAKE_REGS_SVH
`define STANDBY_WAKE_REGS_SVH

// register addresses on the cpu data port
`define SETTLE_SEL_ADDR 16'hFFFA
`define REQ_FLAGS_ADDR 16'hFFE2
`define MASK_FLAGS_ADDR 16'hFFE6
`define KEY_CTL_ADDR 16'hFFF6

// reset values
`define SETTLE_SEL_RESET 3'h4
`define REQ_FLAGS_RESET 8'h00
`define MASK_FLAGS_RESET 8'hFF
`define KEY_CTL_RESET 2'h2

// field positions
`define WATCH_FLAG_BIT 0
`define WATCH_MASK_BIT 0
`define KEY_FLAG_BIT 0
`define KEY_MASK_BIT 1
`define SETTLE_SEL_W 3
`define KEY_CTL_W 2

// settle codes
`define SETTLE_CODE_0 3'h0
`define SETTLE_CODE_1 3'h1
`define SETTLE_CODE_2 3'h2
`define SETTLE_CODE_3 3'h3
`define SETTLE_CODE_4 3'h4

// settle waits in main system clock periods
`define SETTLE_CYC_0 4096
`define SETTLE_CYC_1 16384
`define SETTLE_CYC_2 32768
`define SETTLE_CYC_3 65536
`define SETTLE_CYC_4 131072
// wait after reset, in oscillator periods
`define RESET_SETTLE_CYC 131072
// counter width able to hold the longest doubled wait
`define SETTLE_CNT_W 19

`endif

// ===== rtl/standby_wake_pkg.sv
package standby_wake_pkg;

typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_OSC_WAIT,
    ST_SETTLE
} standby_state_t;

typedef struct packed {
    standby_state_t state;
    logic [7:0] req_flags;
    logic [7:0] mask_flags;
    logic [1:0] key_ctl;
    logic [2:0] settle_sel;
    logic [7:0] key_sync1;
    logic [7:0] key_sync2;
    logic [7:0] key_prev;
    logic osc_sync1;
    logic osc_sync2;
    logic reset_wait;
    logic release_req;
    logic resume;
    logic [7:0] rd_data;
} standby_regs_t;

endpackage

// ===== rtl/settle_counter.sv
`timescale 1ns/1ps
`include "standby_wake_regs.svh"

module settle_counter #(
    parameter int CNT_W = `SETTLE_CNT_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic run,
    input wire logic [CNT_W-1:0] target,
    output logic done
);

typedef struct packed {
    logic [CNT_W-1:0] count;
} settle_cnt_t;

settle_cnt_t cur_ff;
settle_cnt_t nxt_cur;

if (CNT_W < 2) begin : g_width_check
    $error("settle_counter: CNT_W too small");
end

// counting from zero while run is held; done on the last cycle
assign done = run && (cur_ff.count == target - 1'b1);

always_comb begin
    nxt_cur = cur_ff;
    if (!run) begin
        nxt_cur.count = '0;
    end else if (!done) begin
        nxt_cur.count = cur_ff.count + 1'b1;
    end
end

always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
        cur_ff <= '0;
    end else begin
        cur_ff <= nxt_cur;
    end
end

endmodule // settle_counter

// ===== testbench/osc_startup_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// main oscillator: dies at once when disabled, restarts slowly
module osc_startup_model #(
    parameter int START_CYC = 6
) (
    input wire logic clock,
    input wire logic osc_enable,
    output logic osc_running
);
    int cnt = 0;
    initial osc_running = 1'b0;
    // start-up time must not count toward the settle wait
    always @(posedge clock) begin
        if (!osc_enable) begin
            cnt <= 0;
            osc_running <= 1'b0;
        end else if (cnt < START_CYC) begin
            cnt <= cnt + 1;
        end else begin
            osc_running <= 1'b1;
        end
    end
endmodule // osc_startup_model

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "standby_wake_regs.svh"
module testbench;
    logic clock, rst, cpu_wr, cpu_rd, halt_exec, stop_exec, irq_pending;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata, cpu_rdata, key_port_pins;
    logic watch_overflow_event, oscillation_divide_select, osc_running;
    logic cpu_clock_enable, osc_enable, halt_active, stop_active;
    logic release_req, resume;
    int err_count = 0;
    int comparisons = 0;
    int n, t_ref, t_rst;
    typedef struct {logic [2:0] code; logic div; int cyc;} row_t;
    // shortest wait cut to SC0 cycles, the others keep their ratios
    localparam int SC0 = 4;
    row_t rows[9] = '{'{3'h0, 1'b1, 4}, '{3'h0, 1'b1, 4},
        '{3'h1, 1'b1, 16}, '{3'h2, 1'b1, 32}, '{3'h3, 1'b1, 64},
        '{3'h4, 1'b1, 128}, '{3'h2, 1'b0, 64}, '{3'h4, 1'b0, 256},
        '{3'h5, 1'b1, 128}};

    standby_wake_control #(.SETTLE_CYC_0(SC0)) standby_wake_control_inst (
        .clock, .rst,
        .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .halt_exec,
        .stop_exec, .irq_pending, .watch_overflow_event, .key_port_pins,
        .oscillation_divide_select, .osc_running, .cpu_clock_enable,
        .osc_enable, .halt_active, .stop_active, .release_req, .resume);
    osc_startup_model #(.START_CYC(6)) osc_startup_model_inst (.clock,
        .osc_enable, .osc_running);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clock);
        cpu_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clock);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clock);
        cpu_rd = 1'b0;
        check("cpu_rdata", cpu_rdata, exp);
    endtask

    task automatic standby(input logic stop);
        @(negedge clock);
        stop_exec = stop; // main clock, peripherals idle
        halt_exec = !stop; // no converter running
        @(negedge clock);
        stop_exec = 1'b0;
        halt_exec = 1'b0;
    endtask

    // bounded wait for the cpu clock, n holds the cycles spent
    task automatic wait_run(input int lim);
        n = 0;
        while (cpu_clock_enable !== 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        check("cpu_clock_enable", cpu_clock_enable, 1'b1);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        cpu_addr = 16'h0000;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
        halt_exec = 1'b0;
        stop_exec = 1'b0;
        irq_pending = 1'b0;
        watch_overflow_event = 1'b0;
        key_port_pins = 8'hFF;
        oscillation_divide_select = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        wait_run(200);
        t_rst = n;
        check("reset_wait", t_rst,
              3 + SC0 * (`RESET_SETTLE_CYC / `SETTLE_CYC_0));
        wr(`MASK_FLAGS_ADDR, 8'hFE);
        // stop, wake by watch overflow; only deltas are exact
        foreach (rows[i]) begin
            wr(`SETTLE_SEL_ADDR, {5'h00, rows[i].code});
            oscillation_divide_select = rows[i].div;
            standby(1'b1);
            check("osc_enable", osc_enable, 1'b0);
            check("stop_active", stop_active, 1'b1);
            watch_overflow_event = 1'b1;
            @(negedge clock);
            watch_overflow_event = 1'b0;
            wait_run(2000);
            check("resume", resume, 1'b1);
            if (i == 0) t_ref = n;
            check("settle", n - t_ref, rows[i].cyc - 4);
            wr(`REQ_FLAGS_ADDR, 8'h00);
        end
        check("osc_delay", t_ref >= 10, 1'b1);
        rd(`MASK_FLAGS_ADDR, 8'hFE);
        rd(`SETTLE_SEL_ADDR, 8'h05);
        // watch event: flag and release request on one edge, for one cycle
        @(negedge clock);
        watch_overflow_event = 1'b1;
        @(negedge clock);
        watch_overflow_event = 1'b0;
        check("release_req", release_req, 1'b1);
        @(negedge clock);
        check("release_req", release_req, 1'b0);
        rd(`REQ_FLAGS_ADDR, 8'h01);
        // masked flag keeps halt until the mask opens
        wr(`MASK_FLAGS_ADDR, 8'hFF);
        standby(1'b0);
        check("halt_active", halt_active, 1'b1);
        check("osc_enable", osc_enable, 1'b1);
        check("cpu_clock_enable", cpu_clock_enable, 1'b0);
        repeat (5) @(negedge clock);
        check("halt_active", halt_active, 1'b1);
        wr(`MASK_FLAGS_ADDR, 8'hFE);
        wait_run(10);
        check("resume", resume, 1'b1);
        wr(`REQ_FLAGS_ADDR, 8'h00);
        // key flag is sticky even after the pin returns high
        key_port_pins = 8'hF7;
        repeat (6) @(negedge clock);
        key_port_pins = 8'hFF;
        repeat (6) @(negedge clock);
        rd(`KEY_CTL_ADDR, 8'h03);
        wr(`KEY_CTL_ADDR, 8'h00);
        rd(`KEY_CTL_ADDR, 8'h00);
        standby(1'b0);
        key_port_pins = 8'h7F;
        wait_run(10);
        key_port_pins = 8'hFF;
        wr(`KEY_CTL_ADDR, 8'h02);
        // interrupt ends halt on the next edge
        standby(1'b0);
        irq_pending = 1'b1;
        @(negedge clock);
        check("cpu_clock_enable", cpu_clock_enable, 1'b1);
        check("resume", resume, 1'b1);
        // pending interrupt: stop never turns the oscillator off
        standby(1'b1);
        check("stop_active", stop_active, 1'b0);
        check("osc_enable", osc_enable, 1'b1);
        irq_pending = 1'b0;
        wait_run(200);
        check("pending_wait", n,
              SC0 * (`SETTLE_CYC_4 / `SETTLE_CYC_0));
        // second reset with halved clock: same wait as the first
        oscillation_divide_select = 1'b0;
        rst = 1'b1;
        repeat (3) @(negedge clock);
        check("cpu_clock_enable", cpu_clock_enable, 1'b0);
        rst = 1'b0;
        wait_run(200);
        check("reset_wait", n, t_rst);
        rd(`SETTLE_SEL_ADDR, 8'h04);
        rd(`REQ_FLAGS_ADDR, 8'h00);
        rd(`MASK_FLAGS_ADDR, 8'hFF);
        rd(`KEY_CTL_ADDR, 8'h02);
        wr(16'hFFE0, 8'h5A);
        rd(16'hFFE0, 8'h00);
        tally_and_finish();
    end
endmodule // testbench
